// ---- tmu_consts.svh ----
// Bit layout, select codes and reset values of the thermal monitor unit
`ifndef TMU_CONSTS_SVH
`define TMU_CONSTS_SVH
// Register selects on the special-register port
`define TMU_SEL_FIRST 2'h0
`define TMU_SEL_SECOND 2'h1
`define TMU_SEL_SAMPLING 2'h2
// Threshold register fields (bit 0 is the msb, so doc bit n is [31-n])
`define TMU_THR_CROSS_BIT 31
`define TMU_THR_VALID_BIT 30
`define TMU_THR_LEVEL_MSB 29
`define TMU_THR_LEVEL_LSB 23
`define TMU_THR_DIR_BIT 2
`define TMU_THR_IRQEN_BIT 1
`define TMU_THR_V_BIT 0
// Sampling control fields
`define TMU_SMP_ITV_MSB 13
`define TMU_SMP_ITV_LSB 1
`define TMU_SMP_EN_BIT 0
// Reset values
`define TMU_RST_WORD 32'h0000_0000
`define TMU_RST_ITV 13'h0000
`define TMU_RST_LEVEL 7'h00
`endif

// ---- tmu_pkg.sv ----
// Types shared by the thermal monitor unit modules
package tmu_pkg;
  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SETTLE
  } tmu_seq_e;
  // One threshold register with its status and halt
  typedef struct packed {
    logic crossed;
    logic valid;
    logic [6:0] level;
    logic dir_below;
    logic irq_en;
    logic v;
    logic halt;
  } tmu_slot_s;
  // Special-register access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [31:0] wdata;
  } tmu_spr_req_s;
  // Whole state of the top
  typedef struct packed {
    tmu_seq_e st;
    logic sel;
    logic [12:0] cnt;
    logic [12:0] itv;
    logic en;
    logic pending;
    logic irq;
    logic [31:0] rdata;
    logic fault;
    logic [6:0] dac;
    logic dac_en;
    logic cmp_s1;
    logic cmp_s2;
  } tmu_top_s;
endpackage : tmu_pkg

// ---- tmu_slot.sv ----
// One threshold register: fields, crossing and validity flags, halt
`timescale 1ns/1ps
`default_nettype none
`include "tmu_consts.svh"
module tmu_slot (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  input wire logic i_clear,
  input wire logic i_sample,
  input wire logic i_temp_above,
  output tmu_pkg::tmu_slot_s o_slot,
  output logic [31:0] o_word,
  output logic o_irq_event
);
  tmu_pkg::tmu_slot_s s_q; // Registered slot state
  tmu_pkg::tmu_slot_s s_d; // Next slot state
  logic crossed; // Comparison result under the chosen direction

  // Direction flips what counts as a crossing
  assign crossed = s_q.dir_below ? !i_temp_above : i_temp_above; // RL8
  assign o_irq_event = i_sample && crossed && s_q.irq_en; // RL9
  assign o_slot = s_q;
  // Read view; reserved bits read as zero
  always_comb begin
    o_word = `TMU_RST_WORD;
    o_word[`TMU_THR_CROSS_BIT] = s_q.crossed; // RL4 RL17
    o_word[`TMU_THR_VALID_BIT] = s_q.valid; // RL5
    o_word[`TMU_THR_LEVEL_MSB:`TMU_THR_LEVEL_LSB] = s_q.level; // RL6
    o_word[`TMU_THR_DIR_BIT] = s_q.dir_below;
    o_word[`TMU_THR_IRQEN_BIT] = s_q.irq_en;
    o_word[`TMU_THR_V_BIT] = s_q.v; // RL11
  end

  // Next state: a write beats a sample in the same cycle
  always_comb begin
    s_d = s_q;
    if (i_wr) begin
      // A write reloads the fields and restarts this slot; the crossing flag is kept
      s_d.level = i_wdata[`TMU_THR_LEVEL_MSB:`TMU_THR_LEVEL_LSB]; // RL6
      s_d.dir_below = i_wdata[`TMU_THR_DIR_BIT];
      s_d.irq_en = i_wdata[`TMU_THR_IRQEN_BIT];
      s_d.v = i_wdata[`TMU_THR_V_BIT];
      s_d.valid = 1'b0; // RL18
      s_d.halt = 1'b0; // RL18
    end else if (i_clear) begin
      // Sampling control written: validity flag drops, halt lifts
      s_d.valid = 1'b0; // RL18
      s_d.halt = 1'b0;
    end else if (i_sample && !s_q.halt) begin
      s_d.crossed = crossed; // RL4
      s_d.valid = 1'b1; // RL5
      // Interrupting slot freezes its flags until it or sampling control is written
      if (crossed && s_q.irq_en) begin
        s_d.halt = 1'b1; // RL19
      end
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_q <= '0; // RL1
    end else begin
      s_q <= s_d;
    end
  end

  property p_write_clears_valid;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_wr |=> !s_q.valid && !s_q.halt;
  endproperty
  a_write_clears_valid: assert property (p_write_clears_valid) // RL18
    else $error("valid flag survived a register write");

  property p_halt_holds;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (s_q.halt && !i_wr && !i_clear) |=>
        ($stable(s_q.crossed) && $stable(s_q.valid));
  endproperty
  a_halt_holds: assert property (p_halt_holds) // RL19
    else $error("flags moved while slot was halted");

  property p_direction;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_sample && !s_q.halt && !i_wr && !i_clear) |=>
        (s_q.valid && s_q.crossed ==
         ($past(s_q.dir_below) ^ $past(i_temp_above)));
  endproperty
  a_direction: assert property (p_direction) // RL8
    else $error("crossing flag disagrees with direction");
endmodule : tmu_slot
`default_nettype wire

// ---- tmu_top.sv ----
// Thermal monitor unit: registers, sample sequencer, interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "tmu_consts.svh"
// Operation
// [RL1] Hard reset clears all registers; unit idles.
// [RL2] Periodically compare temperature; interrupt on crossing.
// [RL3] Registers reachable only at supervisor level.
// [RL4] Bit 0: read-only crossing flag.
// [RL5] Bit 1: read-only validity flag.
// [RL6] Bits 2-8: seven-bit threshold, one degree.
// [RL7] Software writes zero to reserved bits.
// [RL8] Bit 29 picks above or below direction.
// [RL9] Bit 30 enables interrupt; flag updates regardless.
// [RL10] Interrupt masked by external interrupt enable.
// [RL11] Bit 31 valid; senses with unit enable.
// [RL12] Unit enable runs compare with any valid.
// [RL13] Bits 18-30: settle cycles before sampling.
// [RL14] Software aims for about twenty microsecond interval.
// [RL15] Single and dual threshold operation supported.
// [RL16] Drive threshold to DAC; read comparator.
// [RL17] Bit 0 is the register msb.
// [RL18] Writes clear validity and restart comparison.
// [RL19] After interrupt, suspend sampling and hold flags.
// [RL20] Dual mode alternates; interrupting register stops.
// [RL21] Request held until interrupt unit recognises.
module tmu_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire tmu_pkg::tmu_spr_req_s i_spr_req,
  input wire logic i_supervisor,
  input wire logic i_external_irq_enable,
  input wire logic i_irq_ack,
  input wire logic i_comparator,
  output logic [31:0] o_spr_rdata,
  output logic o_spr_fault,
  output logic o_thermal_irq,
  output logic [6:0] o_dac_code,
  output logic o_dac_enable
);
  tmu_pkg::tmu_top_s r_q; // Registered state
  tmu_pkg::tmu_top_s r_d; // Next state
  tmu_pkg::tmu_slot_s slot_first; // First threshold register view
  tmu_pkg::tmu_slot_s slot_second; // Second threshold register view
  logic [31:0] word_first; // Read word of the first register
  logic [31:0] word_second; // Read word of the second register
  logic [31:0] word_smp; // Read word of sampling control
  logic priv_ok; // Access allowed at this privilege
  logic wr_first; // Granted write to first register
  logic wr_second; // Granted write to second register
  logic wr_smp; // Granted write to sampling control
  logic wr_any; // Any granted write, restarts the sequencer
  logic act_first; // First register takes part in sensing
  logic act_second; // Second register takes part in sensing
  logic act_cur; // Register under test is still active
  logic act_other; // The other register is active
  logic smp_first; // Sample strobe into the first register
  logic smp_second; // Sample strobe into the second register
  logic sample; // Comparator is sampled this cycle
  logic ev_first; // First register raised an interrupt event
  logic ev_second; // Second register raised an interrupt event

  // Only supervisor state may touch the registers
  assign priv_ok = i_supervisor; // RL3
  assign wr_first = i_spr_req.wr && priv_ok &&
                    i_spr_req.sel == `TMU_SEL_FIRST; // RL3
  assign wr_second = i_spr_req.wr && priv_ok &&
                     i_spr_req.sel == `TMU_SEL_SECOND;
  assign wr_smp = i_spr_req.wr && priv_ok &&
                  i_spr_req.sel == `TMU_SEL_SAMPLING;
  assign wr_any = wr_first || wr_second || wr_smp;

  // Participation needs both the register valid bit and unit enable
  assign act_first = r_q.en && slot_first.v && !slot_first.halt; // RL11
  assign act_second = r_q.en && slot_second.v && !slot_second.halt;
  assign act_cur = r_q.sel ? act_second : act_first;
  assign act_other = r_q.sel ? act_first : act_second;

  // Sample when the settle count has run out
  assign sample = r_q.st == tmu_pkg::ST_SETTLE && r_q.cnt == 13'h0000 &&
                  act_cur && !wr_any; // RL13
  assign smp_first = sample && !r_q.sel;
  assign smp_second = sample && r_q.sel;

  // Sampling control read view; reserved bits read as zero
  always_comb begin
    word_smp = `TMU_RST_WORD;
    word_smp[`TMU_SMP_ITV_MSB:`TMU_SMP_ITV_LSB] = r_q.itv; // RL13
    word_smp[`TMU_SMP_EN_BIT] = r_q.en; // RL12
  end

  // The two threshold registers share one implementation
  tmu_slot u_slot_first (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(wr_first),
    .i_wdata(i_spr_req.wdata),
    .i_clear(wr_smp),
    .i_sample(smp_first),
    .i_temp_above(r_q.cmp_s2),
    .o_slot(slot_first),
    .o_word(word_first),
    .o_irq_event(ev_first)
  );

  tmu_slot u_slot_second (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(wr_second),
    .i_wdata(i_spr_req.wdata),
    .i_clear(wr_smp),
    .i_sample(smp_second),
    .i_temp_above(r_q.cmp_s2),
    .o_slot(slot_second),
    .o_word(word_second),
    .o_irq_event(ev_second)
  );

  // Next state of registers, sequencer and interrupt request
  always_comb begin
    r_d = r_q;
    // Comparator is analog and asynchronous: two flops first
    r_d.cmp_s1 = i_comparator;
    r_d.cmp_s2 = r_q.cmp_s1;
    // Privilege fault pulse for a user-mode access attempt
    r_d.fault = (i_spr_req.rd || i_spr_req.wr) && !priv_ok; // RL3
    // Read data is captured and held until the next granted read
    if (i_spr_req.rd && priv_ok) begin
      case (i_spr_req.sel)
        `TMU_SEL_FIRST: r_d.rdata = word_first;
        `TMU_SEL_SECOND: r_d.rdata = word_second;
        `TMU_SEL_SAMPLING: r_d.rdata = word_smp;
        default: r_d.rdata = `TMU_RST_WORD;
      endcase
    end
    // Sampling control write; reserved bits are dropped
    if (wr_smp) begin
      r_d.itv = i_spr_req.wdata[`TMU_SMP_ITV_MSB:`TMU_SMP_ITV_LSB]; // RL13
      r_d.en = i_spr_req.wdata[`TMU_SMP_EN_BIT]; // RL12
    end
    // Sequencer
    case (r_q.st)
      tmu_pkg::ST_IDLE: begin
        // Any write while idle just lets the fresh setup settle in
        if (!wr_any && (act_first || act_second)) begin // RL12
          r_d.sel = !act_first; // RL15
          r_d.cnt = r_q.itv; // RL13
          r_d.dac = act_first ? slot_first.level : slot_second.level;
          r_d.dac_en = 1'b1; // RL16
          r_d.st = tmu_pkg::ST_SETTLE;
        end else begin
          // Analog path parked in low power while nothing is sensed
          r_d.dac_en = 1'b0; // RL1
        end
      end
      tmu_pkg::ST_SETTLE: begin
        if (wr_any || !act_cur) begin
          // Restart from the top with whatever is now configured
          r_d.st = tmu_pkg::ST_IDLE; // RL18 RL19
        end else if (r_q.cnt == 13'h0000) begin
          // Sampled now; move on, alternating when both are live
          r_d.sel = act_other ? !r_q.sel : r_q.sel; // RL20
          r_d.dac = (act_other ^ r_q.sel) ? slot_second.level :
                    slot_first.level; // RL16
          r_d.cnt = r_q.itv; // RL2
        end else begin
          r_d.cnt = r_q.cnt - 13'h0001; // RL13
        end
      end
      default: begin
        r_d.st = tmu_pkg::ST_IDLE;
      end
    endcase
    // Request held until recognised; a new event wins over the ack
    if (ev_first || ev_second) begin
      r_d.pending = 1'b1; // RL2 RL21
    end else if (i_irq_ack) begin
      r_d.pending = 1'b0; // RL21
    end
    // Masked by the core's external interrupt enable
    r_d.irq = r_d.pending && i_external_irq_enable; // RL10
  end

  // State register; everything clears on hard reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      r_q <= '0; // RL1
    end else begin
      r_q <= r_d;
    end
  end

  assign o_spr_rdata = r_q.rdata;
  assign o_spr_fault = r_q.fault;
  assign o_thermal_irq = r_q.irq;
  assign o_dac_code = r_q.dac;
  assign o_dac_enable = r_q.dac_en;

  property p_reset_idle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      $fell(i_sys_rst) |-> (!o_dac_enable && !o_thermal_irq &&
                            r_q.itv == `TMU_RST_ITV && !r_q.en);
  endproperty
  a_reset_idle: assert property (p_reset_idle) // RL1
    else $error("unit not idle and clear after reset");

  property p_user_no_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_spr_req.wr && !i_supervisor) |=>
        ($stable(r_q.itv) && $stable(r_q.en) && o_spr_fault);
  endproperty
  a_user_no_write: assert property (p_user_no_write) // RL3
    else $error("user-mode write changed sampling control");

  property p_irq_mask;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_thermal_irq |-> $past(i_external_irq_enable) && r_q.pending;
  endproperty
  a_irq_mask: assert property (p_irq_mask) // RL10
    else $error("interrupt raised while masked");

  property p_irq_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (r_q.pending && !i_irq_ack) |=> r_q.pending;
  endproperty
  a_irq_hold: assert property (p_irq_hold) // RL21
    else $error("interrupt request dropped before recognition");

  property p_disabled_idle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!r_q.en && !wr_smp) |=> r_q.st == tmu_pkg::ST_IDLE ##1 !o_dac_enable;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // RL12
    else $error("sequencer runs with unit disabled");

  property p_settle_load;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (r_q.st == tmu_pkg::ST_IDLE && r_d.st == tmu_pkg::ST_SETTLE) |=>
        (r_q.cnt == r_q.itv && o_dac_enable);
  endproperty
  a_settle_load: assert property (p_settle_load) // RL13
    else $error("settle count not loaded from interval");

  property p_dual_alternate;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (sample && !r_q.sel && act_second) |=>
        (r_q.sel && o_dac_code == slot_second.level);
  endproperty
  a_dual_alternate: assert property (p_dual_alternate) // RL20
    else $error("dual mode failed to alternate");

  // A user-mode access attempt must be flagged on the next cycle
  property p_fault_pulse;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ((i_spr_req.rd || i_spr_req.wr) && !i_supervisor) |=> o_spr_fault;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) // RL3
    else $error("refused access raised no fault");

  // The fault flag is a pulse, never raised by a granted access
  property p_fault_quiet;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !((i_spr_req.rd || i_spr_req.wr) && !i_supervisor) |=> !o_spr_fault;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) // RL3
    else $error("fault raised without a refused access");

  // Sampling control reads back its fields, reserved bits as zero
  property p_smp_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_spr_req.rd && i_supervisor &&
       i_spr_req.sel == `TMU_SEL_SAMPLING) |=>
        (o_spr_rdata == {18'h0_0000, $past(r_q.itv), $past(r_q.en)});
  endproperty
  a_smp_read: assert property (p_smp_read) // RL13
    else $error("sampling control read back wrong");

  // Nothing to sense: the analog path drops to low power
  property p_idle_dac_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (r_q.st == tmu_pkg::ST_IDLE && !act_first && !act_second) |=>
        !o_dac_enable;
  endproperty
  a_idle_dac_off: assert property (p_idle_dac_off) // RL1
    else $error("DAC left on with nothing to sense");

  // Settle counter steps down by one while nothing interferes
  property p_count_down;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (r_q.st == tmu_pkg::ST_SETTLE && r_q.cnt != 13'h0000 && act_cur &&
       !wr_any) |=> (r_q.cnt == $past(r_q.cnt) - 13'h0001);
  endproperty
  a_count_down: assert property (p_count_down) // RL13
    else $error("settle counter did not count down");

  // A crossing with interrupts enabled always leaves a request
  property p_event_pending;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (ev_first || ev_second) |=> r_q.pending;
  endproperty
  a_event_pending: assert property (p_event_pending) // RL2
    else $error("crossing event lost");

  // Recognition with no new event retires the request
  property p_ack_clears;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_irq_ack && !ev_first && !ev_second) |=> !r_q.pending;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // RL21
    else $error("request survived recognition");

  // The comparator is only believed while the DAC is driven
  property p_sample_dac_on;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      sample |-> o_dac_enable;
  endproperty
  a_sample_dac_on: assert property (p_sample_dac_on) // RL16
    else $error("sampled with the DAC switched off");
endmodule : tmu_top
`default_nettype wire

// ---- tmu_far_model.sv ----
// Far side model: analog comparator and the core's interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tmu_far_model #(
  parameter int ACK_DLY = 5 // Cycles before the core recognises a request
) (
  input wire logic i_core_clk,
  input wire logic [6:0] i_dac_code,
  input wire logic i_dac_enable,
  input wire logic [6:0] i_temp,
  input wire logic i_thermal_irq,
  input wire logic i_ack_on,
  output logic o_comparator,
  output logic o_irq_ack
);
  logic idle_tgl_q = 1'h0; // Unsettled comparator pattern
  int wait_q = 0; // Cycles the request has stood
  // Comparator is only meaningful while the DAC is driven
  always_comb begin
    if (i_dac_enable) begin
      o_comparator = (i_temp > i_dac_code);
    end else begin
      // Toggle so an undriven DAC never looks like a stable answer
      o_comparator = idle_tgl_q;
    end
  end
  // Core answers only while allowed and after a fixed latency
  assign o_irq_ack = i_thermal_irq && i_ack_on && (wait_q >= ACK_DLY);
  // Count how long the request has been held
  always_ff @(posedge i_core_clk) begin
    idle_tgl_q <= ~idle_tgl_q;
    if (i_thermal_irq && i_ack_on) begin
      wait_q <= wait_q + 1;
    end else begin
      wait_q <= 0;
    end
  end
endmodule : tmu_far_model
`default_nettype wire

// ---- tmu_tb.sv ----
// Self-checking bench of the thermal monitor unit
`timescale 1ns/1ps
`default_nettype none
`include "tmu_consts.svh"
module testbench;
  logic clk = 1'h0; // Core clock
  logic rst = 1'h1; // Hard reset
  tmu_pkg::tmu_spr_req_s req = '0; // Register port
  logic sup = 1'h1; // Supervisor level
  logic ee = 1'h0; // External interrupt enable
  logic ack_on = 1'h0; // Lets the core answer
  logic [6:0] temp = 7'h00; // Junction temperature
  logic cmp, ack, fault, irq, dac_en;
  logic [31:0] rdata;
  logic [6:0] dac;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 32'h5fea;
  tmu_top i_tmu_top (.i_core_clk(clk), .i_sys_rst(rst),
    .i_spr_req(req), .i_supervisor(sup), .i_external_irq_enable(ee),
    .i_irq_ack(ack), .i_comparator(cmp), .o_spr_rdata(rdata),
    .o_spr_fault(fault), .o_thermal_irq(irq), .o_dac_code(dac),
    .o_dac_enable(dac_en));
  tmu_far_model i_tmu_far_model (.i_core_clk(clk), .i_dac_code(dac),
    .i_dac_enable(dac_en), .i_temp(temp), .i_thermal_irq(irq),
    .i_ack_on(ack_on), .o_comparator(cmp), .o_irq_ack(ack));
  // Free running 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Verdict and end of run
  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_rst;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    #1 rst = 1'h0;
  endtask : do_rst
  // One register access, held for exactly the taking edge
  task automatic acc(input logic rd, input logic wr, input logic [1:0] s,
                     input logic [31:0] wd);
    @(posedge clk);
    #1 req = '{rd: rd, wr: wr, sel: s, wdata: wd};
    @(posedge clk);
    #1 req = '0;
  endtask : acc
  task automatic rdreg(input logic [1:0] s, output logic [31:0] w);
    acc(1'h1, 1'h0, s, 32'h0000_0000);
    w = rdata;
  endtask : rdreg
  // Poll until the flags are valid; a hang ends the run
  task automatic wait_valid(input logic [1:0] s, output logic [31:0] w);
    for (int i = 0; i < 300; i++) begin
      rdreg(s, w);
      if (w[30] === 1'h1) return;
    end
    n_mismatch++;
    complete_run();
  endtask : wait_valid
  function automatic logic [31:0] thr(input logic [6:0] l, input logic d,
                                      input logic ie, input logic v);
    return {2'h0, l, 20'h0_0000, d, ie, v};
  endfunction : thr
  // Expected crossing for a direction, threshold and temperature
  function automatic logic xc(input logic d, input logic [6:0] l,
                              input logic [6:0] t);
    return d ? (t < l) : (t > l);
  endfunction : xc
  // Main sequence
  initial begin
    logic [31:0] w;
    logic [6:0] lvl, lv2;
    logic [12:0] itv;
    logic sa, sb;
    do_rst();
    for (int s = 0; s < 3; s++) begin
      rdreg(s[1:0], w);
      chk(w, 32'h0000_0000);
    end
    chk({31'h0, dac_en}, 32'h0000_0000);
    // Refused user access leaves the register alone
    sup = 1'h0;
    acc(1'h0, 1'h1, `TMU_SEL_SAMPLING, 32'h0000_0003);
    chk({31'h0, fault}, 32'h0000_0001);
    sup = 1'h1;
    rdreg(`TMU_SEL_SAMPLING, w);
    chk(w, 32'h0000_0000);
    acc(1'h0, 1'h1, 2'h3, 32'hFFFF_FFFF);
    rdreg(2'h3, w);
    chk(w, 32'h0000_0000);
    // Interval kept far below twenty microseconds to bound run time
    itv = 13'h0008 + 13'($random(seed) & 31);
    acc(1'h0, 1'h1, `TMU_SEL_SAMPLING, {18'h0_0000, itv, 1'h1});
    rdreg(`TMU_SEL_SAMPLING, w);
    chk(w, {18'h0_0000, itv, 1'h1});
    ee = 1'h1;
    // Single threshold sensing, both directions, no interrupt
    for (int k = 0; k < 10; k++) begin
      lvl = 7'($random(seed));
      temp = 7'($random(seed));
      if (k == 2) begin
        lvl = 7'h7F;
        temp = 7'h00;
      end
      if (k == 3) begin
        lvl = 7'h00;
        temp = 7'h7F;
      end
      if (temp == lvl) temp = lvl ^ 7'h01;
      acc(1'h0, 1'h1, `TMU_SEL_FIRST, thr(lvl, k[0], 1'h0, 1'h1));
      rdreg(`TMU_SEL_FIRST, w);
      chk({31'h0, w[30]}, 32'h0000_0000);
      wait_valid(`TMU_SEL_FIRST, w);
      chk(w, {xc(k[0], lvl, temp), 1'h1, lvl, 20'h0_0000, k[0], 2'h1});
      chk({31'h0, irq}, 32'h0000_0000);
    end
    // Unit disabled: no sensing even with a valid threshold
    acc(1'h0, 1'h1, `TMU_SEL_SAMPLING, {18'h0_0000, itv, 1'h0});
    acc(1'h0, 1'h1, `TMU_SEL_FIRST, thr(7'h20, 1'h0, 1'h0, 1'h1));
    repeat (3 * itv + 10) @(posedge clk);
    rdreg(`TMU_SEL_FIRST, w);
    chk({31'h0, w[30]}, 32'h0000_0000);
    chk({31'h0, dac_en}, 32'h0000_0000);
    // Enabled but no register marked valid
    acc(1'h0, 1'h1, `TMU_SEL_FIRST, thr(7'h20, 1'h0, 1'h0, 1'h0));
    acc(1'h0, 1'h1, `TMU_SEL_SAMPLING, {18'h0_0000, itv, 1'h1});
    repeat (3 * itv + 10) @(posedge clk);
    rdreg(`TMU_SEL_FIRST, w);
    chk({31'h0, w[30]}, 32'h0000_0000);
    // Dual threshold: DAC must alternate between both levels
    lvl = 7'($random(seed));
    lv2 = lvl ^ 7'h40;
    temp = 7'($random(seed));
    if (temp == lvl || temp == lv2) temp = lvl ^ 7'h01;
    acc(1'h0, 1'h1, `TMU_SEL_FIRST, thr(lvl, 1'h0, 1'h0, 1'h1));
    acc(1'h0, 1'h1, `TMU_SEL_SECOND, thr(lv2, 1'h1, 1'h0, 1'h1));
    sa = 1'h0;
    sb = 1'h0;
    for (int i = 0; i < 8 * (itv + 1); i++) begin
      @(posedge clk);
      #1;
      if (dac_en === 1'h1 && dac === lvl) sa = 1'h1;
      if (dac_en === 1'h1 && dac === lv2) sb = 1'h1;
    end
    chk({30'h0, sa, sb}, 32'h0000_0003);
    wait_valid(`TMU_SEL_SECOND, w);
    chk({31'h0, w[31]}, {31'h0, xc(1'h1, lv2, temp)});
    wait_valid(`TMU_SEL_FIRST, w);
    chk({31'h0, w[31]}, {31'h0, xc(1'h0, lvl, temp)});
    // Interrupt: masked, raised, held and frozen until recognised
    acc(1'h0, 1'h1, `TMU_SEL_SECOND, thr(7'h00, 1'h0, 1'h0, 1'h0));
    ee = 1'h0;
    lvl = 7'($random(seed) & 63);
    temp = lvl + 7'h10;
    acc(1'h0, 1'h1, `TMU_SEL_FIRST, thr(lvl, 1'h0, 1'h1, 1'h1));
    wait_valid(`TMU_SEL_FIRST, w);
    chk(w, {2'h3, lvl, 20'h0_0000, 3'h3});
    chk({31'h0, irq}, 32'h0000_0000);
    ee = 1'h1;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    temp = 7'h00;
    repeat (4 * itv + 10) @(posedge clk);
    rdreg(`TMU_SEL_FIRST, w);
    chk(w, {2'h3, lvl, 20'h0_0000, 3'h3});
    chk({31'h0, irq}, 32'h0000_0001);
    ack_on = 1'h1;
    // Look just after each edge so the registered output has settled
    for (int i = 0; i < 50 && irq !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, irq}, 32'h0000_0000);
    ack_on = 1'h0;
    // Second reset in mid-run clears everything again
    do_rst();
    for (int s = 0; s < 3; s++) begin
      rdreg(s[1:0], w);
      chk(w, 32'h0000_0000);
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
